/* File: rtl/otp_seq.sv */
// command sequencer for read, extended read and programming of the otp data memory
`timescale 1ns/100ps
// Function
// - read command F0h is followed by address, low byte then high byte.
// - plain read returns successive bytes from start address until end or reset.
// - after last byte, plain read sends crc of command, address and data.
// - after end crc, every read slot answers one until reset.
// - reset aborts plain read anywhere; an aborted read gives no crc.
// - extended read A5h sends redirection byte of the starting page first.
// - first extended pass: crc over command, address and redirection byte.
// - extended read sends data to page end, then crc of those bytes.
// - then next redirection byte and its own crc, then data from page start.
// - after last page crc, ones until reset; reset aborts anytime.
// - write takes address and data byte, returns crc of command, address, data.
// - memory erased to ones; pulse clears bits where scratchpad bit is zero.
// - after pulse, stored byte returned on eight slots, lsb first.
// - after verify the address always increments and preloads the crc.
// - later passes: next data byte shifts into preloaded crc, crc returned.
// - reset terminates a write at any step, back to command wait.
// - all bits travel least significant bit first.
// - write code 0Fh; nine upper address bits forced to zero.
module otp_seq #(
	parameter int unsigned MEM_BYTES = otp_seq_pkg::MEM_BYTES,
	parameter int unsigned N_PAGES   = otp_seq_pkg::N_PAGES
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 bus_reset_i,
	input  wire logic                 wr_valid_i,
	input  wire logic                 wr_bit_i,
	input  wire logic                 rd_req_i,
	input  wire logic                 prog_done_i,
	input  wire logic [N_PAGES*8-1:0] redir_bytes_i,
	output logic                      rd_bit_o,
	output logic                      busy_o
);

	typedef struct packed {
		otp_seq_pkg::state_t             st;
		otp_seq_pkg::state_t             after;
		logic [7:0]                      cmd;
		logic [7:0]                      target_addr_low;
		logic [7:0]                      data;
		logic [15:0]                     sh;
		logic [15:0]                     crc;
		logic [4:0]                      cnt;
		logic                            out;
		logic [MEM_BYTES-1:0][7:0]       mem;
	} regs_t;

	regs_t       q;
	regs_t       d;
	logic        sending;
	logic        crc_bit;
	logic [15:0] crc_nx;
	logic [7:0]  rx;

	// states in which read slots carry sequencer data
	assign sending = (q.st == otp_seq_pkg::ST_SEND_DATA) || (q.st == otp_seq_pkg::ST_SEND_REDIR)
		|| (q.st == otp_seq_pkg::ST_SEND_CRC) || (q.st == otp_seq_pkg::ST_VERIFY);

	// crc sees received bits, or the bit leaving on this read slot
	assign crc_bit = sending ? q.sh[0] : wr_bit_i;
	assign rx      = {wr_bit_i, q.sh[15:9]}; // byte complete on the eighth bit

	crc16_step u_crc (
		.crc_i (q.crc),
		.bit_i (crc_bit),
		.crc_o (crc_nx)
	);

	// next state; the lower layer delivers one event per slot
	always_comb
	begin
		d = q;
		if (bus_reset_i)
		begin
			// reset pulse drops any sequence, no crc follows
			d.st  = otp_seq_pkg::ST_CMD;
			d.crc = otp_seq_pkg::CRC_CLEAR;
			d.cnt = otp_seq_pkg::CNT_RST;
		end
		else
		begin
			unique case (q.st)
				otp_seq_pkg::ST_CMD, otp_seq_pkg::ST_ADDR_LO,
				otp_seq_pkg::ST_ADDR_HI, otp_seq_pkg::ST_DATA_IN:
				begin
					if (wr_valid_i)
					begin
						d.sh  = {wr_bit_i, q.sh[15:1]};
						d.crc = crc_nx; // command, address and data all enter the crc
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == otp_seq_pkg::BYTE_LAST)
						begin
							d.cnt = otp_seq_pkg::CNT_RST;
							unique case (q.st)
								otp_seq_pkg::ST_CMD:
								begin
									d.cmd = rx;
									// unknown codes park until the next reset
									if (rx == otp_seq_pkg::CMD_READ || rx == otp_seq_pkg::CMD_EXT_READ
										|| rx == otp_seq_pkg::CMD_WRITE)
										d.st = otp_seq_pkg::ST_ADDR_LO;
									else
										d.st = otp_seq_pkg::ST_DEAD;
								end
								otp_seq_pkg::ST_ADDR_LO:
								begin
									// bit 7 dropped; the crc still holds what was sent
									d.target_addr_low = rx & otp_seq_pkg::ADDR_MASK;
									d.st              = otp_seq_pkg::ST_ADDR_HI;
								end
								otp_seq_pkg::ST_ADDR_HI:
								begin
									// high byte only feeds the crc, so a nonzero one comes back in the next crc as sent and raises no mismatch
									if (q.cmd == otp_seq_pkg::CMD_READ)
									begin
										d.sh = {otp_seq_pkg::ERASED_BYTE, q.mem[q.target_addr_low[6:0]]};
										d.st = otp_seq_pkg::ST_SEND_DATA;
									end
									else if (q.cmd == otp_seq_pkg::CMD_EXT_READ)
									begin
										d.sh = {otp_seq_pkg::ERASED_BYTE,
											redir_bytes_i[8*q.target_addr_low[6:5] +: 8]};
										d.st = otp_seq_pkg::ST_SEND_REDIR;
									end
									else
										d.st = otp_seq_pkg::ST_DATA_IN;
								end
								default:
								begin
									// scratchpad loaded, crc goes back before the pulse
									d.data  = rx;
									d.sh    = ~crc_nx;
									d.st    = otp_seq_pkg::ST_SEND_CRC;
									d.after = otp_seq_pkg::ST_WAIT_PROG;
								end
							endcase
						end
					end
				end
				otp_seq_pkg::ST_SEND_DATA:
				begin
					if (rd_req_i)
					begin
						d.sh  = {1'b1, q.sh[15:1]};
						d.crc = crc_nx;
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == otp_seq_pkg::BYTE_LAST)
						begin
							d.cnt = otp_seq_pkg::CNT_RST;
							if (q.target_addr_low == otp_seq_pkg::LAST_ADDR)
							begin
								// end of memory: crc, then ones
								d.sh    = ~crc_nx;
								d.st    = otp_seq_pkg::ST_SEND_CRC;
								d.after = otp_seq_pkg::ST_ONES;
							end
							else if (q.cmd == otp_seq_pkg::CMD_EXT_READ
								&& q.target_addr_low[4:0] == otp_seq_pkg::PAGE_LAST_OFS)
							begin
								// page end: crc of this page's data, then next redirection
								d.sh    = ~crc_nx;
								d.st    = otp_seq_pkg::ST_SEND_CRC;
								d.after = otp_seq_pkg::ST_SEND_REDIR;
							end
							else
							begin
								d.target_addr_low = q.target_addr_low + 8'h01;
								d.sh = {otp_seq_pkg::ERASED_BYTE, q.mem[d.target_addr_low[6:0]]};
							end
						end
					end
				end
				otp_seq_pkg::ST_SEND_REDIR:
				begin
					if (rd_req_i)
					begin
						d.sh  = {1'b1, q.sh[15:1]};
						d.crc = crc_nx;
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == otp_seq_pkg::BYTE_LAST)
						begin
							d.cnt   = otp_seq_pkg::CNT_RST;
							d.sh    = ~crc_nx;
							d.st    = otp_seq_pkg::ST_SEND_CRC;
							d.after = otp_seq_pkg::ST_SEND_DATA;
						end
					end
				end
				otp_seq_pkg::ST_SEND_CRC:
				begin
					if (rd_req_i)
					begin
						d.sh  = {1'b1, q.sh[15:1]}; // inverted crc, lsb first
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == otp_seq_pkg::CRC_LAST)
						begin
							d.cnt = otp_seq_pkg::CNT_RST;
							d.st  = q.after;
							if (q.after == otp_seq_pkg::ST_SEND_DATA)
							begin
								// page data crc starts from a cleared generator
								d.crc = otp_seq_pkg::CRC_CLEAR;
								d.sh  = {otp_seq_pkg::ERASED_BYTE, q.mem[q.target_addr_low[6:0]]};
							end
							else if (q.after == otp_seq_pkg::ST_SEND_REDIR)
							begin
								// later passes: crc of the redirection byte alone
								d.target_addr_low = q.target_addr_low + 8'h01;
								d.crc = otp_seq_pkg::CRC_CLEAR;
								d.sh  = {otp_seq_pkg::ERASED_BYTE,
									redir_bytes_i[8*d.target_addr_low[6:5] +: 8]};
							end
						end
					end
				end
				otp_seq_pkg::ST_WAIT_PROG:
				begin
					// the pulse is the master's call alone; read slots meanwhile give ones
					if (prog_done_i)
					begin
						// otp can only clear bits
						d.mem[q.target_addr_low[6:0]] = q.mem[q.target_addr_low[6:0]] & q.data;
						d.sh  = {otp_seq_pkg::ERASED_BYTE, d.mem[q.target_addr_low[6:0]]};
						d.cnt = otp_seq_pkg::CNT_RST;
						d.st  = otp_seq_pkg::ST_VERIFY;
					end
				end
				otp_seq_pkg::ST_VERIFY:
				begin
					if (rd_req_i)
					begin
						d.sh  = {1'b1, q.sh[15:1]};
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == otp_seq_pkg::BYTE_LAST)
						begin
							// increment regardless of verify result; master judges
							d.cnt             = otp_seq_pkg::CNT_RST;
							d.target_addr_low = q.target_addr_low + 8'h01;
							d.crc             = {otp_seq_pkg::ADDR_HIGH_RST, d.target_addr_low};
							d.st              = otp_seq_pkg::ST_DATA_IN;
						end
					end
				end
				otp_seq_pkg::ST_ONES, otp_seq_pkg::ST_DEAD:
				begin
					d.st = q.st; // ones on every slot until reset
				end
			endcase
		end
		// next read slot bit; idle slots read as one
		d.out = ((d.st == otp_seq_pkg::ST_SEND_DATA) || (d.st == otp_seq_pkg::ST_SEND_REDIR)
			|| (d.st == otp_seq_pkg::ST_SEND_CRC) || (d.st == otp_seq_pkg::ST_VERIFY))
			? d.sh[0] : 1'b1;
	end

	// state register; erased memory reads as ones
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			q.st              <= otp_seq_pkg::ST_CMD;
			q.after           <= otp_seq_pkg::ST_ONES;
			q.cmd             <= otp_seq_pkg::BYTE_RST;
			q.target_addr_low <= otp_seq_pkg::BYTE_RST;
			q.data            <= otp_seq_pkg::BYTE_RST;
			q.sh              <= otp_seq_pkg::SHIFT_RST;
			q.crc             <= otp_seq_pkg::CRC_CLEAR;
			q.cnt             <= otp_seq_pkg::CNT_RST;
			q.out             <= 1'b1;
			q.mem             <= '1;
		end
		else
			q <= d;
	end

	assign rd_bit_o = q.out;
	assign busy_o   = (q.st != otp_seq_pkg::ST_CMD);

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_last_verify;
		(q.st == otp_seq_pkg::ST_VERIFY) && rd_req_i && !bus_reset_i
			&& (q.cnt == otp_seq_pkg::BYTE_LAST);
	endsequence

	sequence s_addr_done(logic [7:0] c);
		(q.st == otp_seq_pkg::ST_ADDR_HI) && wr_valid_i && !bus_reset_i
			&& (q.cnt == otp_seq_pkg::BYTE_LAST) && (q.cmd == c);
	endsequence

	AST_RESET_ABORT: assert property (bus_reset_i |=> (q.st == otp_seq_pkg::ST_CMD)
		&& (q.crc == otp_seq_pkg::CRC_CLEAR))
		else $error("reset pulse did not return to command wait");
	AST_ONES_AFTER_END: assert property ((q.st == otp_seq_pkg::ST_ONES)
		&& !bus_reset_i |=> rd_bit_o && (q.st == otp_seq_pkg::ST_ONES))
		else $error("read slot after end crc not one");
	AST_LSB_FIRST: assert property (sending |-> (rd_bit_o == q.sh[0]))
		else $error("read slot bit is not lsb of shifter");
	AST_PROG_AND: assert property ((q.st == otp_seq_pkg::ST_WAIT_PROG) && prog_done_i
		&& !bus_reset_i |=> (q.mem[q.target_addr_low[6:0]]
		== ($past(q.mem[q.target_addr_low[6:0]]) & q.data)) && (q.st == otp_seq_pkg::ST_VERIFY))
		else $error("programming pulse did not and scratchpad into memory");
	AST_VERIFY_INC: assert property (s_last_verify |=> (q.target_addr_low
		== $past(q.target_addr_low) + 8'h01) && (q.crc == {8'h00, q.target_addr_low})
		&& (q.st == otp_seq_pkg::ST_DATA_IN))
		else $error("address not incremented and preloaded after verify");
	AST_REDIR_FIRST: assert property (s_addr_done(otp_seq_pkg::CMD_EXT_READ) |=>
		(q.st == otp_seq_pkg::ST_SEND_REDIR)
		&& (q.sh[7:0] == redir_bytes_i[8*q.target_addr_low[6:5] +: 8]))
		else $error("extended read did not start with redirection byte");
	AST_WRITE_MASK: assert property (s_addr_done(otp_seq_pkg::CMD_WRITE) |=>
		(q.target_addr_low[7] == 1'b0) && (q.st == otp_seq_pkg::ST_DATA_IN))
		else $error("write address upper bits not forced to zero");
	AST_CRC_LEN: assert property ((q.st == otp_seq_pkg::ST_SEND_CRC) |->
		(q.cnt <= otp_seq_pkg::CRC_LAST))
		else $error("crc phase ran beyond sixteen slots");
	AST_CRC_INV: assert property ((q.st == otp_seq_pkg::ST_DATA_IN) && wr_valid_i && !bus_reset_i
		&& (q.cnt == otp_seq_pkg::BYTE_LAST) |=> (q.sh == ~$past(crc_nx)) ##1 1'b1)
		else $error("write crc not loaded inverted");
	AST_READ_START: assert property (s_addr_done(otp_seq_pkg::CMD_READ) |=>
		(q.st == otp_seq_pkg::ST_SEND_DATA) && (q.sh[7:0] == q.mem[q.target_addr_low[6:0]]))
		else $error("plain read did not start at given address");

endmodule // otp_seq

/* File: rtl/otp_seq_pkg.sv */
// constants and state encoding shared by the one-time-programmable memory sequencer
package otp_seq_pkg;

	// memory geometry
	localparam int unsigned MEM_BYTES  = 128;
	localparam int unsigned PAGE_BYTES = 32;
	localparam int unsigned N_PAGES    = 4;

	// command codes
	localparam logic [7:0] CMD_READ     = 8'hF0;
	localparam logic [7:0] CMD_EXT_READ = 8'hA5;
	localparam logic [7:0] CMD_WRITE    = 8'h0F;

	// address handling: upper bits forced to zero, last byte and last byte of a page
	localparam logic [7:0] ADDR_MASK     = 8'h7F;
	localparam logic [7:0] LAST_ADDR     = 8'h7F;
	localparam logic [4:0] PAGE_LAST_OFS = 5'h1F;
	localparam logic [7:0] ADDR_HIGH_RST = 8'h00;

	// crc16, x^16 + x^15 + x^2 + 1 in reflected form
	localparam logic [15:0] CRC_POLY_REV = 16'hA001;
	localparam logic [15:0] CRC_CLEAR    = 16'h0000;

	// reset and fill values
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam logic [15:0] SHIFT_RST   = 16'hFFFF;
	localparam logic [7:0]  BYTE_RST    = 8'h00;

	// slot counts, as last index of a field
	localparam logic [4:0] CNT_RST      = 5'h00;
	localparam logic [4:0] BYTE_LAST    = 5'h07;
	localparam logic [4:0] CRC_LAST     = 5'h0F;

	// sequencer states
	typedef enum logic [3:0] {
		ST_CMD,
		ST_ADDR_LO,
		ST_ADDR_HI,
		ST_DATA_IN,
		ST_SEND_DATA,
		ST_SEND_REDIR,
		ST_SEND_CRC,
		ST_WAIT_PROG,
		ST_VERIFY,
		ST_ONES,
		ST_DEAD
	} state_t;

endpackage

/* File: rtl/crc16_step.sv */
// one bit step of the reflected crc16 generator
`timescale 1ns/100ps
module crc16_step (
	input  wire logic [15:0] crc_i,
	input  wire logic        bit_i,
	output logic      [15:0] crc_o
);

	logic fb;

	// feedback from the low end because bits travel lsb first
	assign fb    = crc_i[0] ^ bit_i;
	assign crc_o = (crc_i >> 1) ^ (fb ? otp_seq_pkg::CRC_POLY_REV : otp_seq_pkg::CRC_CLEAR);

endmodule // crc16_step

/* File: dv/otp_master_model.sv */
// bus master controller model: turns slot-level requests into sequencer events
`timescale 1ns/100ps
module otp_master_model (
	input  wire logic sys_clk_i,
	input  wire logic rd_bit_i,
	output logic      bus_reset_o,
	output logic      wr_valid_o,
	output logic      wr_bit_o,
	output logic      rd_req_o,
	output logic      prog_done_o
);
	// all events idle at time zero
	initial
	begin
		bus_reset_o = 1'b0;
		wr_valid_o  = 1'b0;
		wr_bit_o    = 1'b0;
		rd_req_o    = 1'b0;
		prog_done_o = 1'b0;
	end

	// one write slot per cycle; the bit line flips after release so a stale value never helps
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk_i);
			#1 wr_bit_o = b[i];
			wr_valid_o = 1'b1;
		end
		@(posedge sys_clk_i);
		#1 wr_valid_o = 1'b0;
		wr_bit_o = ~wr_bit_o;
	endtask

	// read slots back to back; each bit is taken before the slot consumes it
	task automatic recv(input int n, output logic [15:0] v);
		v = 16'h0000;
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk_i);
			#1 v[i] = rd_bit_i;
			rd_req_o = 1'b1;
		end
		@(posedge sys_clk_i);
		#1 rd_req_o = 1'b0;
	endtask

	// one-cycle reset pulse on the wire
	task automatic reset_pulse();
		@(posedge sys_clk_i);
		#1 bus_reset_o = 1'b1;
		@(posedge sys_clk_i);
		#1 bus_reset_o = 1'b0;
	endtask

	// end of the programming pulse; callers issue it only after a matching crc
	task automatic prog_pulse();
		@(posedge sys_clk_i);
		#1 prog_done_o = 1'b1;
		@(posedge sys_clk_i);
		#1 prog_done_o = 1'b0;
	endtask
endmodule // otp_master_model

/* File: dv/tb_otp_seq.sv */
// self-checking bench for the otp memory access sequencer
`timescale 1ns/100ps
module tb_otp_seq;
	localparam logic [31:0] REDIR = 32'hFEFD_FCFF;
	logic        sys_clk_i;
	logic        nrst_i;
	logic        bus_reset_i;
	logic        wr_valid_i;
	logic        wr_bit_i;
	logic        rd_req_i;
	logic        prog_done_i;
	logic        rd_bit_o;
	logic        busy_o;
	logic [7:0]  mem [128];
	int          bad_count;
	int          compares;
	int          cycles;

	otp_seq uut (
		.sys_clk_i     (sys_clk_i),
		.nrst_i        (nrst_i),
		.bus_reset_i   (bus_reset_i),
		.wr_valid_i    (wr_valid_i),
		.wr_bit_i      (wr_bit_i),
		.rd_req_i      (rd_req_i),
		.prog_done_i   (prog_done_i),
		.redir_bytes_i (REDIR),
		.rd_bit_o      (rd_bit_o),
		.busy_o        (busy_o)
	);

	otp_master_model m (
		.sys_clk_i   (sys_clk_i),
		.rd_bit_i    (rd_bit_o),
		.bus_reset_o (bus_reset_i),
		.wr_valid_o  (wr_valid_i),
		.wr_bit_o    (wr_bit_i),
		.rd_req_o    (rd_req_i),
		.prog_done_o (prog_done_i)
	);

	// 100 MHz clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// reflected crc16, one byte lsb first; kept separate from the design's step
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
		logic fb;
		for (int i = 0; i < 8; i++)
		begin
			fb = c[0] ^ b[i];
			c  = c >> 1;
			if (fb)
				c = c ^ 16'hA001;
		end
		return c;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// command byte then both address bytes, high byte kept zero
	task automatic header(input logic [7:0] cmd, input logic [7:0] a, output logic [15:0] c);
		m.send(cmd);
		m.send(a);
		m.send(8'h00);
		c = crc8(crc8(crc8(16'h0000, cmd), a), 8'h00);
	endtask

	// two program passes: first at a, second at the auto-incremented address
	task automatic do_write(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
		logic [15:0] c;
		logic [15:0] v;
		logic [7:0]  d [2];
		d[0] = d0;
		d[1] = d1;
		header(otp_seq_pkg::CMD_WRITE, a, c);
		for (int p = 0; p < 2; p++)
		begin
			m.send(d[p]);
			c = crc8(c, d[p]);
			m.recv(16, v);
			check(v, ~c, "write crc");
			if (v !== ~c)
			begin
				m.reset_pulse();
				return;
			end
			m.prog_pulse();
			mem[a + 8'(p)] &= d[p];
			m.recv(8, v);
			check(v, {8'h00, mem[a + 8'(p)]}, "verify");
			// a one left where a zero was written: drop the pass with a reset pulse and end the write
			if ((v[7:0] & ~d[p]) != 8'h00)
			begin
				m.reset_pulse();
				return;
			end
			c = {8'h00, a + 8'(p) + 8'h01};
		end
		m.reset_pulse();
		check({15'h0000, busy_o}, 16'h0000, "idle after write");
	endtask

	// plain read to the end of memory, end crc, then ones
	task automatic do_read(input logic [7:0] a);
		logic [15:0] c;
		logic [15:0] v;
		header(otp_seq_pkg::CMD_READ, a, c);
		for (int i = a; i < 128; i++)
		begin
			m.recv(8, v);
			check(v, {8'h00, mem[i]}, "read data");
			c = crc8(c, mem[i]);
		end
		m.recv(16, v);
		check(v, ~c, "read crc");
		m.recv(16, v);
		check(v, 16'hFFFF, "read ones");
		m.reset_pulse();
	endtask

	// reads and writes cut short by reset pulses, one with an over-range address
	task automatic do_abort();
		logic [15:0] c;
		logic [15:0] v;
		header(otp_seq_pkg::CMD_READ, 8'hFE, c);
		m.recv(8, v);
		check(v, {8'h00, mem[126]}, "masked read");
		m.recv(5, v);
		m.reset_pulse();
		check({15'h0000, busy_o}, 16'h0000, "idle after read abort");
		header(otp_seq_pkg::CMD_WRITE, 8'h40, c);
		m.reset_pulse();
		check({15'h0000, busy_o}, 16'h0000, "idle after write abort");
		// an unsupported command parks the sequencer on ones until a reset pulse
		m.send(8'h3C);
		m.recv(16, v);
		check(v, 16'hFFFF, "unknown command ones");
		check({15'h0000, busy_o}, 16'h0001, "parked on unknown command");
		m.reset_pulse();
		check({15'h0000, busy_o}, 16'h0000, "idle after unknown command");
	endtask

	// extended read: redirection bytes, their crcs, page data and page crcs
	task automatic do_ext(input logic [7:0] a);
		logic [15:0] c;
		logic [15:0] v;
		int          st;
		header(otp_seq_pkg::CMD_EXT_READ, a, c);
		for (int pg = int'(a[6:5]); pg < 4; pg++)
		begin
			m.recv(8, v);
			check(v, {8'h00, REDIR[8*pg +: 8]}, "redir");
			c = crc8(c, REDIR[8*pg +: 8]);
			m.recv(16, v);
			check(v, ~c, "redir crc");
			c  = 16'h0000;
			st = (pg == int'(a[6:5])) ? int'(a) : pg * 32;
			for (int i = st; i < pg * 32 + 32; i++)
			begin
				m.recv(8, v);
				check(v, {8'h00, mem[i]}, "ext data");
				c = crc8(c, mem[i]);
			end
			m.recv(16, v);
			check(v, ~c, "page crc");
			c = 16'h0000;
		end
		m.recv(16, v);
		check(v, 16'hFFFF, "ext ones");
		m.reset_pulse();
	endtask

	// hang guard
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			finish_test();
		end
	end

	// main sequence
	initial
	begin
		nrst_i    = 1'b0;
		bad_count = 0;
		compares  = 0;
		cycles    = 0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'hFF;
		repeat (3) @(posedge sys_clk_i);
		#1 nrst_i = 1'b1;
		check({15'h0000, busy_o}, 16'h0000, "idle after reset");
		do_write(8'h7E, 8'h3C, 8'hF0);
		do_write(8'h7E, 8'h0F, 8'hFF);
		do_read(8'h7C);
		do_abort();
		do_read(8'h00);
		do_ext(8'h5E);
		finish_test();
	end
endmodule // tb_otp_seq
